// >>> rtl/cdlb_cond.sv
// Purpose: Condition stage shaping the intermediate result by type and time.
// Assumes: step pulses once per scan; time_scans is the time in scans.
// Notes: A time of zero (OFF) makes every type behave as NONE.
`timescale 1ns/1ps
`default_nettype none
module cdlb_cond
   import cdlb_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic step,
   input wire logic din,
   input wire cdlb_cond_e cond_type,
   input wire logic [19:0] time_scans,
   output logic dout
);

   logic [19:0] cnt_r;
   logic [19:0] cnt_nxt;
   logic prev_r;
   logic dout_nxt;
   logic [20:0] cnt_inc;
   logic rise;
   logic expired;

   assign cnt_inc = {1'b0, cnt_r} + 21'h000001;
   assign expired = cnt_inc >= {1'b0, time_scans};
   assign rise = din & ~prev_r;

   ////////////////////////////////////////////////////////////////////////////
   // Next state per type, evaluated only on a scan step.
   always_comb begin
      cnt_nxt = cnt_r;
      dout_nxt = dout;
      if (time_scans == 20'h00000) begin
         dout_nxt = din;
      end else begin
         unique case (cond_type)
            COND_DELAY: begin
               // Output turns on after the input has held ON for the time.
               cnt_nxt = din ? (expired ? cnt_r : cnt_inc[19:0]) : 20'h00000;
               dout_nxt = din & expired;
            end
            COND_EXTEND: begin
               // Output follows the input up and lingers after it falls.
               if (din) begin
                  dout_nxt = 1'b1;
                  cnt_nxt = 20'h00000;
               end else if (dout) begin
                  dout_nxt = ~expired;
                  cnt_nxt = cnt_inc[19:0];
               end
            end
            COND_PULSE, COND_RETRIGGER_PULSE: begin
               // A plain pulse ignores edges while it runs; retrigger restarts.
               if (rise && (!dout || cond_type == COND_RETRIGGER_PULSE)) begin
                  dout_nxt = 1'b1;
                  cnt_nxt = 20'h00000;
               end else if (dout) begin
                  dout_nxt = ~expired;
                  cnt_nxt = cnt_inc[19:0];
               end
            end
            default: begin
               dout_nxt = din;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cnt_r <= 20'h00000;
         prev_r <= 1'b0;
         dout <= 1'b0;
      end else if (step) begin
         cnt_r <= cnt_nxt;
         prev_r <= din;
         dout <= dout_nxt;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/cdlb_pkg.sv
// Purpose: Shared constants and types of the configurable discrete logic block.
// Assumes: 20 MHz mclk, APB register access, one scan every SCAN_PERIOD_MS.
// Notes: Every offset, CTRL and SRC field position, reset value and timing count is named here once.
package cdlb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SCAN_PERIOD_MS = 100;
   localparam int unsigned SCAN_CYCLES = (CLK_HZ / 1000) * SCAN_PERIOD_MS;
   localparam int unsigned SCANS_PER_SEC = 1000 / SCAN_PERIOD_MS;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses) and field layout.
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_SRC = 12'h004;
   localparam logic [11:0] ADDR_CTIME = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_EQ_BASE = 12'h040;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_COND_LSB = 4;
   localparam int unsigned SRC_BITS = 2;
   localparam int unsigned NUM_SRC = 9;
   localparam int unsigned SRC_RESET_IDX = 8;
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam logic [17:0] SRC_RST = 18'h00000;
   localparam logic [15:0] CTIME_RST = 16'h0000;
   localparam logic [31:0] EQ_RST = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // Equation storage and evaluator sizes.
   localparam int unsigned EQ_CHARS = 64;
   localparam int unsigned EQ_WORDS = EQ_CHARS / 4;
   localparam int unsigned STK_DEPTH = 16;
   localparam logic [1:0] NEG_TAIL = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Equation characters.
   localparam logic [7:0] CH_NUL = 8'h00;
   localparam logic [7:0] CH_AND = 8'h2A;
   localparam logic [7:0] CH_OR = 8'h2B;
   localparam logic [7:0] CH_XOR = 8'h5E;
   localparam logic [7:0] CH_LP = 8'h28;
   localparam logic [7:0] CH_RP = 8'h29;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_ONE = 8'h31;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_H = 8'h48;
   localparam logic [7:0] CH_N = 8'h4E;
   localparam logic [7:0] CH_O = 8'h4F;
   localparam logic [7:0] CH_FOLD = 8'hDF;

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [3:0] {MODE_AND, MODE_OR, MODE_XOR, MODE_SET_CLEAR_LATCH, MODE_INVERT_LATCH,
                             MODE_ONE_SHOT, MODE_PASS, MODE_EQUATION, MODE_INVERTER} cdlb_mode_e;
   typedef enum logic [2:0] {COND_NONE, COND_DELAY, COND_EXTEND, COND_PULSE,
                             COND_RETRIGGER_PULSE} cdlb_cond_e;
   typedef enum logic [1:0] {SRC_OFF, SRC_PARAM, SRC_ZERO, SRC_ONE} cdlb_src_e;
   typedef enum logic [2:0] {OP_LP, OP_NOT, OP_AND, OP_OR, OP_XOR} cdlb_op_e;
   typedef enum logic [1:0] {EV_IDLE, EV_RUN, EV_FLUSH, EV_DONE} cdlb_ev_e;

endpackage

// >>> rtl/cdlb_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for discrete pins.
// Assumes: Pins are asynchronous to mclk.
// Notes: A change is accepted once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module cdlb_sync
   import cdlb_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [NUM_SRC-1:0] pin_raw,
   output logic [NUM_SRC-1:0] pin_clean
);

   ////////////////////////////////////////////////////////////////////////////
   // One chain per pin; the first stage feeds only the second.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_pin
         logic s1_r;
         logic s2_r;
         logic s3_r;
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               pin_clean[gi] <= 1'b0;
            end else begin
               s1_r <= pin_raw[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  pin_clean[gi] <= s3_r;
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// >>> rtl/cdlb_top.sv
// Purpose: Configurable discrete logic block with APB registers, one output.
// Assumes: APB master with full-word accesses; discrete pins asynchronous.
// Notes: One scan per SCAN_LEN clocks (SCAN_CYCLES by default); equation evaluated char by char.
//
// Overview of operation
// (R1) AND: result ON only when every programmed input is ON.
// (R2) OR: result ON when at least one programmed input is ON.
// (R3) XOR: only inputs A and B; ON when exactly one is ON.
// (R4) Configure two inputs or more; inputs set OFF are left out.
// (R5) Set/clear latch: A rising sets; B rising clears while A is OFF.
// (R6) Toggle latch: A rising inverts result; falling edges change nothing.
// (R7) One-shot: A rising gives ON for exactly one scan, then OFF.
// (R8) Pass: input A goes unchanged to the condition stage.
// (R9) Condition stage: none, delay, extend, pulse, retrigger pulse, timed in seconds.
// (R10) One discrete output per block after the condition stage.
// (R11) Equation mode takes text of up to 64 characters.
// (R12) Symbols: * AND, + OR, ^ XOR, NEG NOT, A-H inputs, 1/0.
// (R13) Letter O is the block output from the previous scan.
// (R14) Precedence: parentheses, then NOT, then AND, then OR and XOR.
// (R15) Equation mode has eight sources: OFF, parameter, zero or one.
// (R16) Equation mode: reset discrete ON forces the output OFF.
// (R17) Inverter: output is the complement of the single input.
// (R18) Inputs sampled once per scan; edges compare with the previous scan.
`timescale 1ns/1ps
`default_nettype none
module cdlb_top
   import cdlb_pkg::*;
#(
   parameter int unsigned SCAN_LEN = SCAN_CYCLES
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] disc_in,
   input wire logic reset_in,
   output logic block_discrete_output
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [6:0] ctrl_r;
   logic [17:0] src_r;
   logic [15:0] ctime_r;
   logic [31:0] eq_r [EQ_WORDS];
   logic [NUM_SRC-1:0] pin_clean;
   logic [NUM_SRC-1:0] src_val;
   logic [NUM_SRC-1:0] src_prog;
   logic [NUM_SRC-1:0] cur_r;
   logic [NUM_SRC-1:0] prev_r;
   logic [20:0] scan_cnt_r;
   logic scan_tick_r;
   logic result_r;
   logic result_nxt;
   logic step_d_r;
   logic cond_out;
   logic [19:0] time_scans;
   cdlb_mode_e mode;
   cdlb_cond_e cond_type;

   cdlb_ev_e st_r;
   cdlb_ev_e st_nxt;
   logic [6:0] idx_r;
   logic [6:0] idx_nxt;
   logic [1:0] skip_r;
   logic [1:0] skip_nxt;
   logic [STK_DEPTH-1:0] vstk_r;
   logic [STK_DEPTH-1:0] vstk_nxt;
   logic [4:0] vsp_r;
   logic [4:0] vsp_nxt;
   cdlb_op_e ostk_r [STK_DEPTH];
   cdlb_op_e ostk_nxt [STK_DEPTH];
   logic [4:0] osp_r;
   logic [4:0] osp_nxt;
   logic err_r;
   logic err_nxt;
   logic eq_val_r;
   logic eq_val_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration decode.
   assign mode = cdlb_mode_e'(ctrl_r[CTRL_MODE_LSB +: 4]);
   assign cond_type = cdlb_cond_e'(ctrl_r[CTRL_COND_LSB +: 3]);
   assign time_scans = 20'(ctime_r) * 20'(SCANS_PER_SEC);

   cdlb_sync u_sync (
      .mclk(mclk),
      .reset(reset),
      .pin_raw({reset_in, disc_in}),
      .pin_clean(pin_clean)
   );

   // Each source resolves to OFF, its pin, or a constant.
   genvar gs;
   generate
      for (gs = 0; gs < NUM_SRC; gs = gs + 1) begin : g_src
         cdlb_src_e sel;
         assign sel = cdlb_src_e'(src_r[gs*SRC_BITS +: SRC_BITS]);
         assign src_prog[gs] = (sel != SRC_OFF); // R4 R15
         assign src_val[gs] = (sel == SRC_ONE) | ((sel == SRC_PARAM) & pin_clean[gs]); // R15
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so prdata and pready both come from flops.
   logic acc;
   logic wr_en;
   logic eq_hit;
   logic addr_ok;
   logic [31:0] rd_word;

   assign acc = psel & penable & ~pready;
   assign wr_en = psel & penable & pready & pwrite & ~pslverr;
   assign eq_hit = (paddr[11:6] == ADDR_EQ_BASE[11:6]);
   assign addr_ok = eq_hit | (paddr == ADDR_CTRL) | (paddr == ADDR_SRC) | (paddr == ADDR_CTIME) |
                    (paddr == ADDR_STATUS);
   assign rd_word = eq_hit ? eq_r[paddr[5:2]] :
                    (paddr == ADDR_CTRL) ? {25'h0000000, ctrl_r} :
                    (paddr == ADDR_SRC) ? {14'h0000, src_r} :
                    (paddr == ADDR_CTIME) ? {16'h0000, ctime_r} :
                    (paddr == ADDR_STATUS) ? {19'h00000, (st_r != EV_IDLE), err_r, cur_r,
                                              result_r, block_discrete_output} :
                    32'h00000000;

   // Answer phase: an unmapped address reads zero and flags an error.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= acc;
         pslverr <= acc & ~addr_ok;
         prdata <= acc ? rd_word : 32'h00000000;
      end
   end

   // Configuration registers; a write lands at the edge that sees pready.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_r <= CTRL_RST;
         src_r <= SRC_RST;
         ctime_r <= CTIME_RST;
      end else if (wr_en) begin
         if (paddr == ADDR_CTRL) ctrl_r <= pwdata[6:0];
         if (paddr == ADDR_SRC) src_r <= pwdata[17:0];
         if (paddr == ADDR_CTIME) ctime_r <= pwdata[15:0];
      end
   end

   // Equation text: 64 characters, four to a word, first char in bits 7:0.
   genvar gw;
   generate
      for (gw = 0; gw < EQ_WORDS; gw = gw + 1) begin : g_eq
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               eq_r[gw] <= EQ_RST;
            end else if (wr_en && eq_hit && paddr[5:2] == 4'(gw)) begin
               eq_r[gw] <= pwdata; // R11
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Scan timer and per-scan sampling of every source.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         scan_cnt_r <= 21'h000000;
         scan_tick_r <= 1'b0;
         cur_r <= '0;
         prev_r <= '0;
      end else begin
         scan_tick_r <= (scan_cnt_r == 21'(SCAN_LEN - 1));
         scan_cnt_r <= (scan_cnt_r == 21'(SCAN_LEN - 1)) ? 21'h000000 : scan_cnt_r + 21'h000001;
         if (scan_tick_r) begin
            cur_r <= src_val; // R18
            prev_r <= cur_r; // R18
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Equation evaluator: shunting-yard with immediate reduction, one action per
   // clock. A scan is far longer than the worst case of about 130 clocks.
   logic [7:0] ch;
   logic [7:0] chu;
   logic [4:0] vsp_m1;
   logic [4:0] vsp_m2;
   logic [4:0] osp_m1;
   cdlb_op_e top_op;
   cdlb_op_e new_op;
   logic is_operand;
   logic operand;
   logic is_binop;

   assign ch = eq_r[idx_r[5:2]][{idx_r[1:0], 3'b000} +: 8];
   assign chu = ch & CH_FOLD;
   assign vsp_m1 = vsp_r - 5'h01;
   assign vsp_m2 = vsp_r - 5'h02;
   assign osp_m1 = osp_r - 5'h01;
   assign top_op = ostk_r[osp_m1[3:0]];
   assign is_operand = (chu >= CH_A && chu <= CH_H) || chu == CH_O || ch == CH_ZERO || ch == CH_ONE; // R12
   assign operand = (chu == CH_O) ? block_discrete_output : // R13
                    (ch == CH_ONE) ? 1'b1 :
                    (ch == CH_ZERO) ? 1'b0 :
                    cur_r[3'(chu - CH_A)]; // R12 R15
   assign is_binop = (ch == CH_AND) || (ch == CH_OR) || (ch == CH_XOR);
   assign new_op = (ch == CH_AND) ? OP_AND : (ch == CH_OR) ? OP_OR : OP_XOR; // R12

   // Binding strength; the open parenthesis never reduces.
   function automatic logic [1:0] cdlb_prec(input cdlb_op_e op);
      unique case (op)
         OP_NOT: cdlb_prec = 2'h3;
         OP_AND: cdlb_prec = 2'h2;
         OP_OR, OP_XOR: cdlb_prec = 2'h1;
         default: cdlb_prec = 2'h0;
      endcase
   endfunction

   always_comb begin
      logic reduce;
      logic push_v;
      logic push_o;
      cdlb_op_e op_in;
      reduce = 1'b0;
      push_v = 1'b0;
      push_o = 1'b0;
      op_in = OP_LP;
      st_nxt = st_r;
      idx_nxt = idx_r;
      skip_nxt = skip_r;
      vstk_nxt = vstk_r;
      vsp_nxt = vsp_r;
      ostk_nxt = ostk_r;
      osp_nxt = osp_r;
      err_nxt = err_r;
      eq_val_nxt = eq_val_r;
      unique case (st_r)
         EV_IDLE: begin
            if (scan_tick_r) begin
               st_nxt = EV_RUN;
               idx_nxt = 7'h00;
               skip_nxt = 2'h0;
               vsp_nxt = 5'h00;
               osp_nxt = 5'h00;
               err_nxt = 1'b0;
            end
         end
         EV_RUN: begin
            if (idx_r[6] || ch == CH_NUL) begin
               st_nxt = EV_FLUSH; // R11
            end else if (skip_r != 2'h0) begin
               skip_nxt = skip_r - 2'h1;
               idx_nxt = idx_r + 7'h01;
            end else if (is_operand) begin
               push_v = 1'b1;
               idx_nxt = idx_r + 7'h01;
            end else if (chu == CH_N) begin
               // Negation is unary prefix: stacked without reducing anything.
               push_o = 1'b1; // R12 R14
               op_in = OP_NOT;
               skip_nxt = NEG_TAIL;
               idx_nxt = idx_r + 7'h01;
            end else if (ch == CH_LP) begin
               push_o = 1'b1; // R14
               idx_nxt = idx_r + 7'h01;
            end else if (ch == CH_RP) begin
               if (osp_r == 5'h00) begin
                  err_nxt = 1'b1;
                  idx_nxt = idx_r + 7'h01;
               end else if (top_op == OP_LP) begin
                  osp_nxt = osp_m1; // R14
                  idx_nxt = idx_r + 7'h01;
               end else begin
                  reduce = 1'b1;
               end
            end else if (is_binop) begin
               if (osp_r != 5'h00 && top_op != OP_LP && cdlb_prec(top_op) >= cdlb_prec(new_op)) begin
                  reduce = 1'b1; // R14
               end else begin
                  push_o = 1'b1;
                  op_in = new_op;
                  idx_nxt = idx_r + 7'h01;
               end
            end else begin
               idx_nxt = idx_r + 7'h01;
            end
         end
         EV_FLUSH: begin
            if (osp_r == 5'h00) begin
               eq_val_nxt = (vsp_r == 5'h01) & ~err_r & vstk_r[0];
               err_nxt = err_r | (vsp_r != 5'h01);
               st_nxt = EV_DONE;
            end else if (top_op == OP_LP) begin
               osp_nxt = osp_m1;
               err_nxt = 1'b1;
            end else begin
               reduce = 1'b1;
            end
         end
         EV_DONE: begin
            st_nxt = EV_IDLE;
         end
      endcase
      if (push_v) begin
         if (vsp_r[4]) begin
            err_nxt = 1'b1;
         end else begin
            vstk_nxt[vsp_r[3:0]] = operand;
            vsp_nxt = vsp_r + 5'h01;
         end
      end
      if (push_o) begin
         if (osp_r[4]) begin
            err_nxt = 1'b1;
         end else begin
            ostk_nxt[osp_r[3:0]] = op_in;
            osp_nxt = osp_r + 5'h01;
         end
      end
      if (reduce) begin
         osp_nxt = osp_m1;
         if (top_op == OP_NOT) begin
            if (vsp_r == 5'h00) err_nxt = 1'b1;
            else vstk_nxt[vsp_m1[3:0]] = ~vstk_r[vsp_m1[3:0]];
         end else if (vsp_r < 5'h02) begin
            err_nxt = 1'b1;
         end else begin
            vsp_nxt = vsp_m1;
            unique case (top_op)
               OP_AND: vstk_nxt[vsp_m2[3:0]] = vstk_r[vsp_m2[3:0]] & vstk_r[vsp_m1[3:0]];
               OP_OR: vstk_nxt[vsp_m2[3:0]] = vstk_r[vsp_m2[3:0]] | vstk_r[vsp_m1[3:0]];
               default: vstk_nxt[vsp_m2[3:0]] = vstk_r[vsp_m2[3:0]] ^ vstk_r[vsp_m1[3:0]];
            endcase
         end
      end
   end

   // Evaluator registers; stacks need no reset since pointers gate them.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_r <= EV_IDLE;
         idx_r <= 7'h00;
         skip_r <= 2'h0;
         vsp_r <= 5'h00;
         osp_r <= 5'h00;
         err_r <= 1'b0;
         eq_val_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         skip_r <= skip_nxt;
         vsp_r <= vsp_nxt;
         osp_r <= osp_nxt;
         err_r <= err_nxt;
         eq_val_r <= eq_val_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      vstk_r <= vstk_nxt;
      ostk_r <= ostk_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operator stage: runs once per scan when the evaluator finishes.
   logic step;
   logic in_a;
   logic in_b;
   logic rise_a;
   logic rise_b;

   assign step = (st_r == EV_DONE);
   assign in_a = cur_r[0];
   assign in_b = cur_r[1];
   assign rise_a = cur_r[0] & ~prev_r[0]; // R18
   assign rise_b = cur_r[1] & ~prev_r[1]; // R18

   always_comb begin
      result_nxt = result_r;
      unique case (mode)
         MODE_AND: result_nxt = &(cur_r[7:0] | ~src_prog[7:0]); // R1 R4
         MODE_OR: result_nxt = |(cur_r[7:0] & src_prog[7:0]); // R2 R4
         MODE_XOR: result_nxt = in_a ^ in_b; // R3
         MODE_SET_CLEAR_LATCH: begin
            if (rise_a) result_nxt = 1'b1; // R5
            else if (rise_b && !in_a) result_nxt = 1'b0; // R5
         end
         MODE_INVERT_LATCH: result_nxt = result_r ^ rise_a; // R6
         MODE_ONE_SHOT: result_nxt = rise_a; // R7
         MODE_PASS: result_nxt = in_a; // R8
         MODE_EQUATION: result_nxt = eq_val_nxt; // R11
         MODE_INVERTER: result_nxt = ~in_a; // R17
         default: result_nxt = 1'b0;
      endcase
   end

   cdlb_cond u_cond (
      .mclk(mclk),
      .reset(reset),
      .step(step),
      .din(result_nxt),
      .cond_type(cond_type),
      .time_scans(time_scans),
      .dout(cond_out)
   ); // R9

   // Final output one clock after the step, once the condition stage settles.
   // The inverter bypasses the condition stage, as it has no timing prompts.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         result_r <= 1'b0;
         step_d_r <= 1'b0;
         block_discrete_output <= 1'b0;
      end else begin
         step_d_r <= step;
         if (step) result_r <= result_nxt;
         if (step_d_r) begin
            if (mode == MODE_INVERTER) block_discrete_output <= result_r; // R17
            else if (mode == MODE_EQUATION && cur_r[SRC_RESET_IDX]) block_discrete_output <= 1'b0; // R16
            else block_discrete_output <= cond_out; // R10
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb/cdlb_assertions.sv
// Purpose: Port-level timing checks on cdlb_top.
// Assumes: One wait state on every register access.
// Notes: Bound to every cdlb_top instance.
`timescale 1ns/1ps
`default_nettype none
module cdlb_assertions #(
   parameter int unsigned SCAN_LEN = 300
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic block_discrete_output
);
   int gap_r;
   ////////////////////////////////////////
   // Clocks since the output last moved; evaluation time varies, so allow 250 clocks of slack.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         gap_r <= SCAN_LEN;
      end else begin
         gap_r <= $changed(block_discrete_output) ? 0 : ((gap_r < SCAN_LEN) ? gap_r + 1 : gap_r);
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // Bus answers and output pacing.
   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   AST_PULSE: assert property (pready |=> !pready) else $error("pready held");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr alone");
   AST_DATA_QUIET: assert property (!pready |-> prdata == 32'h00000000) else $error("prdata not zero");
   AST_ERR_ZERO: assert property (pslverr |-> prdata == 32'h00000000) else $error("error read data");
   AST_IDLE: assert property (!psel |=> !pready) else $error("pready unselected");
   AST_ACCESS: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
      else $error("access length");
   AST_OUT_GAP: assert property ($changed(block_discrete_output) |-> gap_r >= SCAN_LEN - 250)
      else $error("output moved twice in a scan");
endmodule
bind cdlb_top cdlb_assertions #(.SCAN_LEN(SCAN_LEN)) cdlb_assertions_i (.mclk(mclk), .reset(reset),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .block_discrete_output(block_discrete_output));
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for cdlb_top over APB and the discrete pins.
// Assumes: Scan shortened to 300 clocks; condition stage left at none.
// Notes: Pins are held two scans before the output is judged.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cdlb_pkg::*;
   localparam int SCAN = 300;
   localparam logic [3:0] OPS [4] = '{4'h0, 4'h1, 4'h2, 4'h7};
   // Each step packs mode, pins B and A, and the expected output.
   localparam logic [6:0] SEQ [12] = '{7'h1B, 7'h1F, 7'h1D, 7'h19, 7'h1C, 7'h23, 7'h21, 7'h22,
      7'h33, 7'h30, 7'h41, 7'h42};
   logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reset_in = 1'b0, se;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, rd;
   logic [7:0] disc_in = 8'h00;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, q;
   int err_total = 0, tests_run = 0, cyc = 0;
   always #25 mclk = ~mclk;
   cdlb_top #(.SCAN_LEN(SCAN)) cdlb_top_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .disc_in(disc_in), .reset_in(reset_in), .block_discrete_output(q));
   ////////////////////////////////////////
   // One APB transfer; the request holds until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Two scans cover synchroniser, scan phase and evaluation.
   task automatic pins(input logic [8:0] p);
      @(posedge mclk) {reset_in, disc_in} <= p;
      repeat (2 * SCAN) @(posedge mclk);
   endtask
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic f(input int m, input logic [2:0] p);
      case (m)
         0: return &p;
         1: return |p;
         2: return p[0] ^ p[1];
         default: return (p[0] | p[1]) & p[2];
      endcase
   endfunction
   ////////////////////////////////////////
   // A hang ends the run as a failure.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         close_out();
      end
   end
   // Main sequence; pin D is ON but its source is OFF, so it must not count.
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, se});
      apb(1'b1, ADDR_SRC, 32'h15);
      apb(1'b0, ADDR_SRC, 32'h0);
      chk("src readback", 32'h15, rd);
      apb(1'b1, ADDR_EQ_BASE, 32'h422B4128);
      apb(1'b1, ADDR_EQ_BASE + 12'h004, 32'h00432A29);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, ADDR_CTRL, {28'h0, OPS[m]});
         for (int p = 0; p < 8; p++) begin
            pins({1'b0, 5'h1F, p[2:0]});
            chk("operator", {31'h0, f(m, p[2:0])}, {31'h0, q});
         end
      end
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, ADDR_CTRL, {28'h0, SEQ[i][6:3]});
         pins({7'h0, SEQ[i][2:1]});
         chk("latch pass invert", {31'h0, SEQ[i][0]}, {31'h0, q});
      end
      apb(1'b1, ADDR_CTRL, 32'h5);
      pins(9'h000);
      @(posedge mclk) disc_in <= 8'h01;
      for (int n = 0; n < 3 * SCAN && q !== 1'b1; n++) @(posedge mclk);
      repeat (SCAN - 10) @(posedge mclk);
      chk("one shot on", 32'h1, {31'h0, q});
      repeat (20) @(posedge mclk);
      chk("one shot off", 32'h0, {31'h0, q});
      apb(1'b1, ADDR_SRC, 32'h10001);
      apb(1'b1, ADDR_EQ_BASE, 32'h00412B4F);
      apb(1'b1, ADDR_EQ_BASE + 12'h004, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h7);
      pins(9'h000);
      pins(9'h001);
      pins(9'h000);
      chk("held by feedback", 32'h1, {31'h0, q});
      pins(9'h100);
      chk("block reset", 32'h0, {31'h0, q});
      close_out();
   end
endmodule
`default_nettype wire
